// ===== rtl/dmac_engine.sv
// four-channel dma engine with linked descriptors, tokens, byte swap, time-out and watchdog
`timescale 1ns/1ps

// data fifo between read and write beats
module dmac_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  // clock, reset, flush
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         clr_i,
  // filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];  // storage
  logic [PW-1:0] wr_ptr;   // next slot to fill
  logic [PW-1:0] rd_ptr;   // next slot to drain
  logic [CW-1:0] count;    // words held
  logic          push;
  logic          pop;

  assign in_ready_o  = (count != CW'(D));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointers and occupancy; flush drops everything held
  always_ff @(posedge mclk_i) begin
    if (rst_i || clr_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // storage write
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

module dmac_engine (
  // clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_i,
  // system bus master
  dmac_bus_if.master                               bus,
  // current command load, one channel at a time
  input  wire logic [dmac_pkg::NCH-1:0]            cmd_load_i,
  input  wire logic [31:0]                         cmd_src_i,
  input  wire logic [31:0]                         cmd_dst_i,
  input  wire logic [dmac_pkg::LEN_W-1:0]          cmd_len_i,
  input  wire logic [31:0]                         current_command_control_i,
  // channel control and static setup
  input  wire logic [dmac_pkg::NCH-1:0]            start_i,
  input  wire logic [dmac_pkg::NCH-1:0]            channel_run_enable_i,
  input  wire logic [dmac_pkg::NCH-1:0][dmac_pkg::TOK_W-1:0] rd_tokens_i,
  input  wire logic [dmac_pkg::NCH-1:0][dmac_pkg::TOK_W-1:0] wr_tokens_i,
  input  wire logic [dmac_pkg::NCH-1:0][1:0]       byte_order_i,
  // interrupt enables and clears
  input  wire logic [dmac_pkg::NCH-1:0][dmac_pkg::NST-1:0] int_enable_i,
  input  wire logic [dmac_pkg::NCH-1:0][dmac_pkg::NST-1:0] status_clear_i,
  // status
  output logic      [dmac_pkg::NCH-1:0][dmac_pkg::NST-1:0] raw_irq_status_o,
  output logic      [dmac_pkg::NCH-1:0][dmac_pkg::NST-1:0] masked_irq_status_o,
  output logic      [dmac_pkg::NCH-1:0]            irq_o,
  output logic      [dmac_pkg::NCH-1:0]            channel_active_o
);
  import dmac_pkg::*;

  // round-robin pick after the last served channel
  function automatic logic [1:0] rr_pick(input logic [NCH-1:0] req, input logic [1:0] last);
    logic [1:0] idx;
    logic [1:0] res;
    res = last;
    for (int i = NCH; i >= 1; i--) begin
      idx = last + 2'(i);
      if (req[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction

  // beats per grant: the smaller quota, never zero, never past the fifo
  function automatic logic [QUOTA_W-1:0] quota(input logic [TOK_W-1:0] rt,
                                               input logic [TOK_W-1:0] wt);
    logic [TOK_W-1:0] m;
    m = (rt < wt) ? rt : wt;
    if (m == '0) begin
      m = TOK_W'(1);
    end
    if (m > TOK_W'(FIFO_DEPTH)) begin
      m = TOK_W'(FIFO_DEPTH);
    end
    return QUOTA_W'(m);
  endfunction

  logic [31:0]       src [NCH];     // source address per channel
  logic [31:0]       dst [NCH];     // destination address per channel
  logic [LEN_W-1:0]  len [NCH];     // bytes left per channel
  logic [31:0]       ctl [NCH];     // control word per channel
  logic [NCH-1:0]    started;       // start seen
  logic [NCH-1:0]    ended;         // final command done or time-out
  logic [NCH-1:0]    ready;         // eligible for a grant
  dmac_state_t       state;         // engine state
  dmac_phase_t       phase;         // bus beat phase
  logic [1:0]        cur;           // channel holding the bus
  logic [1:0]        pick;          // next grant candidate
  logic [1:0]        fidx;          // descriptor word being fetched
  logic [QUOTA_W-1:0] cnt;          // read beats this grant
  logic [QUOTA_W-1:0] qta;          // beat limit this grant
  logic [TO_W-1:0]   to_cnt;        // unanswered data phase cycles
  logic [WD_W-1:0]   wd_cnt;        // watchdog wait cycles
  logic [1:0]        wd_ptr;        // channel under watchdog check
  logic              grant;         // a channel starts working
  logic              beat_done;     // data phase answered
  logic              tout;          // data phase time-out
  logic              cmd_fin;       // current command complete
  logic              stall_ev;      // watchdog expiry
  logic              f_in_ready;    // fifo has room
  logic              f_out_valid;   // fifo holds a word
  logic              f_pop;         // fifo drained into write beat
  logic [DW-1:0]     f_out_data;    // fifo head
  logic [NCH-1:0][NST-1:0] next_raw;  // next sticky status

  assign ready     = channel_run_enable_i & started & ~ended;
  assign pick      = rr_pick(ready, cur);
  assign grant     = (state == DMAC_IDLE) && (ready != '0);
  assign beat_done = (phase == DMAC_PH_DATA) && bus.hready;
  assign tout      = (phase == DMAC_PH_DATA) && !bus.hready && (to_cnt == TO_LAST);
  assign cmd_fin   = (state == DMAC_CHECK) && (len[cur] == '0) && channel_run_enable_i[cur];
  assign f_pop     = (state == DMAC_WRITE) && (phase == DMAC_PH_NONE) && f_out_valid;

  // data buffer; a stalled write side backs the read side up
  dmac_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .clr_i       (tout),
    .in_valid_i  (beat_done && (state == DMAC_READ)),
    .in_ready_o  (f_in_ready),
    .in_data_i   (bus.hrdata),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_out_data)
  );

  // time-out counter, only uninterrupted waits reach the limit
  always_ff @(posedge mclk_i) begin
    if (rst_i || phase != DMAC_PH_DATA || bus.hready || tout) begin
      to_cnt <= '0;
    end else begin
      to_cnt <= to_cnt + 1'b1;
    end
  end

  // engine sequencer, command registers and bus drive
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state      <= DMAC_IDLE;
      phase      <= DMAC_PH_NONE;
      cur        <= '0;
      fidx       <= '0;
      cnt        <= '0;
      qta        <= '0;
      started    <= '0;
      ended      <= '0;
      bus.haddr  <= '0;
      bus.htrans <= HTRANS_IDLE;
      bus.hwrite <= 1'b0;
      bus.hsize  <= HSIZE_WORD;
      bus.hwdata <= '0;
      for (int c = 0; c < NCH; c++) begin
        src[c] <= '0;
        dst[c] <= '0;
        len[c] <= '0;
        ctl[c] <= '0;
      end
    end else begin
      // software seeds a command; an empty one pointing at a list chains into it
      for (int c = 0; c < NCH; c++) begin
        if (cmd_load_i[c]) begin
          src[c] <= cmd_src_i;
          dst[c] <= cmd_dst_i;
          len[c] <= cmd_len_i;
          ctl[c] <= current_command_control_i;
        end
        if (start_i[c]) begin
          started[c] <= 1'b1;
          ended[c]   <= 1'b0;
        end
      end
      bus.htrans <= HTRANS_IDLE;
      unique case (state)
        DMAC_IDLE: begin
          if (grant) begin
            cur   <= pick;
            state <= DMAC_CHECK;
          end
        end
        DMAC_CHECK: begin
          if (!channel_run_enable_i[cur]) begin
            // paused between commands: release now, the command completes on resume
            state <= DMAC_IDLE;
          end else if (len[cur] == '0) begin
            // zero length finishes at once
            if (ctl[cur][CTL_LAST_BIT]) begin
              ended[cur] <= 1'b1;
              state      <= DMAC_IDLE;
            end else begin
              fidx  <= DESC_SRC;
              state <= DMAC_FETCH;
            end
          end else begin
            qta   <= quota(rd_tokens_i[cur], wr_tokens_i[cur]);
            cnt   <= '0;
            state <= DMAC_READ;
          end
        end
        default: begin
          if (tout) begin
            // abandon the beat; the flag names this channel
            ended[cur] <= 1'b1;
            phase      <= DMAC_PH_NONE;
            state      <= DMAC_IDLE;
          end else if (phase == DMAC_PH_ADDR) begin
            phase <= DMAC_PH_DATA;
          end else if (phase == DMAC_PH_NONE) begin
            // address phase of the next beat
            if (state == DMAC_FETCH) begin
              bus.haddr  <= {ctl[cur][31:CTL_NEXT_LSB], 2'b00} + {28'h0, fidx, 2'b00};
              bus.hwrite <= 1'b0;
              bus.htrans <= HTRANS_NONSEQ;
              phase      <= DMAC_PH_ADDR;
            end else if (state == DMAC_READ && f_in_ready) begin
              bus.haddr  <= src[cur];
              bus.hwrite <= 1'b0;
              bus.htrans <= HTRANS_NONSEQ;
              phase      <= DMAC_PH_ADDR;
            end else if (f_pop) begin
              bus.haddr  <= dst[cur];
              bus.hwrite <= 1'b1;
              bus.hwdata <= dmac_swap(f_out_data, byte_order_i[cur]);
              bus.htrans <= HTRANS_NONSEQ;
              phase      <= DMAC_PH_ADDR;
            end
          end else if (beat_done) begin
            phase <= DMAC_PH_NONE;
            if (state == DMAC_FETCH) begin
              // words arrive source, destination, length, control
              unique case (fidx)
                DESC_SRC: src[cur] <= bus.hrdata;
                DESC_DST: dst[cur] <= bus.hrdata;
                DESC_LEN: len[cur] <= bus.hrdata[LEN_W-1:0];
                DESC_CTL: ctl[cur] <= bus.hrdata;
              endcase
              fidx <= fidx + 1'b1;
              if (fidx == DESC_CTL) begin
                state <= DMAC_CHECK;
              end
            end else if (state == DMAC_READ) begin
              src[cur] <= src[cur] + WORD_STEP;
              len[cur] <= (len[cur] > LEN_W'(4)) ? len[cur] - LEN_W'(4) : '0;
              cnt      <= cnt + 1'b1;
              // quota spent, buffer empty or paused: flush what was read
              if (cnt + 1'b1 == qta || len[cur] <= LEN_W'(4) ||
                  !channel_run_enable_i[cur]) begin
                state <= DMAC_WRITE;
              end
            end else begin
              dst[cur] <= dst[cur] + WORD_STEP;
              if (!f_out_valid) begin
                // buffer finished goes to completion, else release the bus
                state <= (len[cur] == '0) ? DMAC_CHECK : DMAC_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // watchdog walks active channels one at a time
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wd_ptr <= '0;
      wd_cnt <= '0;
    end else if (!(channel_run_enable_i[wd_ptr] && started[wd_ptr] && !ended[wd_ptr]) ||
                 (grant && pick == wd_ptr) || stall_ev) begin
      wd_ptr <= wd_ptr + 1'b1;
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end
  assign stall_ev = (wd_cnt == WD_LAST) && !(grant && pick == wd_ptr);

  // sticky status: a set in the clearing cycle survives
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      next_raw[c] = raw_irq_status_o[c] & ~status_clear_i[c];
      if (cmd_fin && cur == 2'(c) && ctl[c][CTL_IRQ_BIT]) begin
        next_raw[c][ST_DONE] = 1'b1;
      end
      if (tout && cur == 2'(c)) begin
        next_raw[c][ST_TO_RD] = next_raw[c][ST_TO_RD] | !bus.hwrite;
        next_raw[c][ST_TO_WR] = next_raw[c][ST_TO_WR] | bus.hwrite;
      end
      if (stall_ev && wd_ptr == 2'(c)) begin
        next_raw[c][ST_STALL] = 1'b1;
      end
    end
  end

  // registered status, masked view and per-channel irq
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      raw_irq_status_o    <= '0;
      masked_irq_status_o <= '0;
      irq_o               <= '0;
      channel_active_o    <= '0;
    end else begin
      raw_irq_status_o    <= next_raw;
      masked_irq_status_o <= next_raw & int_enable_i;
      for (int c = 0; c < NCH; c++) begin
        irq_o[c] <= |(next_raw[c] & int_enable_i[c]);
      end
      channel_active_o    <= started & ~ended;
    end
  end
endmodule

// ===== shared/dmac_pkg.sv
// shared constants, types and helpers for the descriptor-chaining dma engine and its ram slave
package dmac_pkg;
  // channel count and data path
  localparam int NCH        = 4;
  localparam int DW         = 32;
  localparam int AW         = 32;
  localparam int LEN_W      = 13;
  localparam int TOK_W      = 6;
  localparam int FIFO_DEPTH = 8;
  localparam int QUOTA_W    = 4;

  // descriptor layout: four words, in this order
  localparam int DESC_WORDS = 4;
  localparam logic [1:0] DESC_SRC = 2'h0;
  localparam logic [1:0] DESC_DST = 2'h1;
  localparam logic [1:0] DESC_LEN = 2'h2;
  localparam logic [1:0] DESC_CTL = 2'h3;

  // control word fields
  localparam int CTL_IRQ_BIT  = 0;
  localparam int CTL_LAST_BIT = 1;
  localparam int CTL_NEXT_LSB = 2;

  // status bit positions within each channel's four-bit status
  localparam int NST       = 4;
  localparam int ST_DONE   = 0;
  localparam int ST_TO_RD  = 1;
  localparam int ST_TO_WR  = 2;
  localparam int ST_STALL  = 3;

  // byte order settings
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_WORD = 2'h1;
  localparam logic [1:0] SWAP_HALF = 2'h2;
  localparam logic [1:0] SWAP_BYTE = 2'h3;

  // bus timing counts, in mclk cycles
  localparam int TIMEOUT_CYCLES = 1024;
  localparam int WDOG_CYCLES    = 2048;
  localparam int TO_W           = 10;
  localparam int WD_W           = 11;
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDOG_CYCLES - 1);

  // bus encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [AW-1:0] WORD_STEP  = 32'h0000_0004;

  // ram slave size
  localparam int MEM_WORDS = 256;
  localparam int MEM_AW    = 8;

  // engine states, gray along idle-check-fetch-read-write
  typedef enum logic [2:0] {
    DMAC_IDLE  = 3'b000,
    DMAC_CHECK = 3'b001,
    DMAC_FETCH = 3'b011,
    DMAC_READ  = 3'b010,
    DMAC_WRITE = 3'b110
  } dmac_state_t;

  // bus beat phase
  typedef enum logic [1:0] {
    DMAC_PH_NONE = 2'b00,
    DMAC_PH_ADDR = 2'b01,
    DMAC_PH_DATA = 2'b11
  } dmac_phase_t;

  // reorder bytes of one written word
  function automatic logic [DW-1:0] dmac_swap(input logic [DW-1:0] d, input logic [1:0] mode);
    logic [DW-1:0] r;
    r = d;
    case (mode)
      SWAP_WORD: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      SWAP_HALF: r = {d[15:0], d[31:16]};
      SWAP_BYTE: r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default:   r = d;
    endcase
    return r;
  endfunction
endpackage

// ===== shared/dmac_bus_if.sv
// word-wide system bus joining the dma engine (master) and the ram slave
`timescale 1ns/1ps
interface dmac_bus_if;
  logic [31:0] haddr;   // address phase address
  logic [1:0]  htrans;  // idle or nonseq
  logic        hwrite;  // write when high
  logic [2:0]  hsize;   // always word
  logic [31:0] hwdata;  // data phase write data
  logic [31:0] hrdata;  // data phase read data
  logic        hready;  // slave ready, low stretches the data phase
  logic        hresp;   // error response

  modport master (output haddr, htrans, hwrite, hsize, hwdata,
                  input  hrdata, hready, hresp);
  modport slave  (input  haddr, htrans, hwrite, hsize, hwdata,
                  output hrdata, hready, hresp);
endinterface

// ===== rtl/dmac_ram_slave.sv
// ram slave on the system bus holding descriptors and buffers, with a host load port
`timescale 1ns/1ps
module dmac_ram_slave (
  // clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // system bus
  dmac_bus_if.slave                      bus,
  // host access to the array
  input  wire logic                      host_we_i,
  input  wire logic [dmac_pkg::MEM_AW-1:0] host_addr_i,
  input  wire logic [31:0]               host_wdata_i,
  output logic      [31:0]               host_rdata_o,
  // holds the bus answer back while high
  input  wire logic                      stall_i
);
  import dmac_pkg::*;

  logic [31:0]       mem [MEM_WORDS];  // descriptor words and buffers alike
  logic              pend;             // data phase outstanding
  logic              pend_wr;          // outstanding beat is a write
  logic [MEM_AW-1:0] pend_idx;         // captured word index

  // capture address phase, answer after at least one wait state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend       <= 1'b0;
      pend_wr    <= 1'b0;
      pend_idx   <= '0;
      bus.hready <= 1'b1;
      bus.hrdata <= '0;
      bus.hresp  <= 1'b0;
    end else if (pend) begin
      // stall keeps hready low so long waits can be provoked
      if (!stall_i) begin
        pend       <= 1'b0;
        bus.hready <= 1'b1;
        bus.hrdata <= pend_wr ? 32'h0000_0000 : mem[pend_idx];
      end
    end else if (bus.htrans == HTRANS_NONSEQ) begin
      pend       <= 1'b1;
      pend_wr    <= bus.hwrite;
      pend_idx   <= bus.haddr[MEM_AW+1:2];
      bus.hready <= 1'b0;
    end
  end

  // array writes: descriptors are plain words, four per entry
  always_ff @(posedge mclk_i) begin
    if (pend && pend_wr && !stall_i) begin
      mem[pend_idx] <= bus.hwdata;
    end
    // host load last so it wins a same-word collision
    if (host_we_i) begin
      mem[host_addr_i] <= host_wdata_i;
    end
  end

  // registered host readback
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      host_rdata_o <= '0;
    end else begin
      host_rdata_o <= mem[host_addr_i];
    end
  end
endmodule

// ===== verif/dmac_bus_chk.sv
// protocol checker watching the bus between the engine and the ram slave
`timescale 1ns/1ps
module dmac_bus_chk
  import dmac_pkg::*;
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // bus signals
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hresp
);
  // one clock domain, so one default for all
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // address phase and stretched data phase
  sequence s_req; htrans == HTRANS_NONSEQ; endsequence
  sequence s_wait; !hready; endsequence

  // descriptor words travel as single beats
  property p_single; s_req |=> htrans == HTRANS_IDLE; endproperty
  a_single: assert property (p_single) else $error("nonseq held over one cycle");
  // slave answers every address phase
  property p_answer; s_req |=> s_wait; endproperty
  a_answer: assert property (p_answer) else $error("address phase not taken");
  // lists may sit anywhere, but always word aligned
  property p_word; s_req |-> hsize == HSIZE_WORD && haddr[1:0] == 2'h0; endproperty
  a_word: assert property (p_word) else $error("beat not word sized or aligned");
  // beats never overlap
  property p_one_beat; s_wait |-> htrans == HTRANS_IDLE; endproperty
  a_one_beat: assert property (p_one_beat) else $error("beat issued while one pending");
  // completion cycle never carries a new address
  property p_gap; $rose(hready) |-> htrans == HTRANS_IDLE; endproperty
  a_gap: assert property (p_gap) else $error("beat issued in completion cycle");
  // pending beat keeps its address and direction
  property p_hold; s_wait |-> $stable(haddr) && $stable(hwrite); endproperty
  a_hold: assert property (p_hold) else $error("address changed in data phase");
  // written word holds from the address phase into the first data phase cycle
  property p_wdata; (htrans == HTRANS_NONSEQ && hwrite) ##1 s_wait |-> $stable(hwdata);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data changed in data phase");
  // the slave never signals an error
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
endmodule

// ===== verif/dmac_descriptor_chain_and_guards_tb.sv
// testbench: engine and ram slave joined, lists, byte order and time-out
`timescale 1ns/1ps
module dmac_descriptor_chain_and_guards_tb;
  import dmac_pkg::*;
  logic                    mclk_i, rst_i, host_we_i, stall_i;  // clock, reset, host strobes
  logic [MEM_AW-1:0]       host_addr_i;                        // host word index
  logic [31:0]             host_wdata_i, host_rdata_o;         // host data
  logic [NCH-1:0]          cmd_load_i, start_i, channel_run_enable_i, irq_o, channel_active_o;
  logic [31:0]             cmd_src_i, cmd_dst_i, current_command_control_i;
  logic [LEN_W-1:0]        cmd_len_i;
  logic [NCH-1:0][TOK_W-1:0] rd_tokens_i, wr_tokens_i;         // quotas per channel
  logic [NCH-1:0][1:0]     byte_order_i;
  logic [NCH-1:0][NST-1:0] int_enable_i, status_clear_i, raw_irq_status_o, masked_irq_status_o;
  int                      n_mismatch, comparisons;
  dmac_bus_if bus_if ();
  dmac_engine u_dmac_engine (.mclk_i(mclk_i), .rst_i(rst_i), .bus(bus_if),
    .cmd_load_i(cmd_load_i), .cmd_src_i(cmd_src_i), .cmd_dst_i(cmd_dst_i),
    .cmd_len_i(cmd_len_i), .current_command_control_i(current_command_control_i),
    .start_i(start_i), .channel_run_enable_i(channel_run_enable_i),
    .rd_tokens_i(rd_tokens_i), .wr_tokens_i(wr_tokens_i), .byte_order_i(byte_order_i),
    .int_enable_i(int_enable_i), .status_clear_i(status_clear_i),
    .raw_irq_status_o(raw_irq_status_o), .masked_irq_status_o(masked_irq_status_o),
    .irq_o(irq_o), .channel_active_o(channel_active_o));
  dmac_ram_slave u_dmac_ram_slave (.mclk_i(mclk_i), .rst_i(rst_i), .bus(bus_if),
    .host_we_i(host_we_i), .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o), .stall_i(stall_i));
  dmac_bus_chk u_dmac_bus_chk (.mclk_i(mclk_i), .rst_i(rst_i), .haddr(bus_if.haddr),
    .htrans(bus_if.htrans), .hwrite(bus_if.hwrite), .hsize(bus_if.hsize),
    .hwdata(bus_if.hwdata), .hready(bus_if.hready), .hresp(bus_if.hresp));

  // expected byte order, written apart from the design's helper
  function automatic logic [31:0] exp_swap(input logic [31:0] d, input logic [1:0] m);
    case (m)
      2'h1: return {<<8{d}};
      2'h2: return {d[15:0], d[31:16]};
      2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: return d;
    endcase
  endfunction
  // inputs move a small fixed delay after the edge
  task automatic tick(input int n); repeat (n) @(posedge mclk_i); #1; endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe left high between writes; caller lowers it once
  task automatic mem_wr(input logic [31:0] a, input logic [31:0] d);
    host_we_i = 1'b1; host_addr_i = a[9:2]; host_wdata_i = d; tick(1);
  endtask
  task automatic mem_rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    host_addr_i = a[9:2]; tick(1); check(what, exp, host_rdata_o);
  endtask
  // load one command, then start the channel
  task automatic seed(input int c, input logic [31:0] s, input logic [31:0] d,
                      input logic [LEN_W-1:0] l, input logic [31:0] ctl);
    cmd_src_i = s; cmd_dst_i = d; cmd_len_i = l; current_command_control_i = ctl;
    cmd_load_i[c] = 1'b1; tick(1); cmd_load_i = '0; start_i[c] = 1'b1; tick(1); start_i = '0;
  endtask
  // bounded poll of one status bit
  task automatic wait_flag(input int c, input int b, input int lim, output int n);
    n = 0;
    while (raw_irq_status_o[c][b] !== 1'b1 && n < lim) begin tick(1); n++; end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin mclk_i = 1'b0; forever #5 mclk_i = ~mclk_i; end
  // watchdog: whole run needs a few thousand cycles
  initial begin repeat (20000) @(posedge mclk_i); n_mismatch++; conclude(); end

  initial begin
    int n;
    rst_i = 1'b1; host_we_i = 1'b0; host_addr_i = '0; host_wdata_i = '0; stall_i = 1'b0;
    cmd_load_i = '0; start_i = '0; cmd_src_i = '0; cmd_dst_i = '0; cmd_len_i = '0;
    current_command_control_i = '0; channel_run_enable_i = '1; byte_order_i = '0;
    rd_tokens_i = {NCH{6'h02}}; wr_tokens_i = {NCH{6'h01}}; int_enable_i = '1;
    status_clear_i = '0; n_mismatch = 0; comparisons = 0;
    tick(8); rst_i = 1'b0;
    // empty head at 0x40 links to a data descriptor at an odd list place, 0x84
    mem_wr(32'h100, 32'h1122_3344); mem_wr(32'h104, 32'h5566_7788);
    mem_wr(32'h40, 32'h100); mem_wr(32'h44, 32'h20c); mem_wr(32'h48, 0); mem_wr(32'h4c, 32'h84);
    mem_wr(32'h84, 32'h100); mem_wr(32'h88, 32'h200); mem_wr(32'h8c, 8); mem_wr(32'h90, 3);
    for (int m = 0; m < 4; m++) begin
      mem_wr(32'h200, 0); mem_wr(32'h204, 0); mem_wr(32'h208, 0); mem_wr(32'h20c, 0);
      host_we_i = 1'b0; byte_order_i[0] = m[1:0];
      seed(0, 0, 0, 0, 32'h40);
      wait_flag(0, ST_DONE, 3000, n);
      check("done", 1, raw_irq_status_o[0][ST_DONE]);
      check("irq", 1, irq_o[0]);
      mem_rd("dst0", 32'h200, exp_swap(32'h1122_3344, m[1:0]));
      mem_rd("dst1", 32'h204, exp_swap(32'h5566_7788, m[1:0]));
      mem_rd("len", 32'h208, 0);
      mem_rd("empty", 32'h20c, 0);
      check("active", 0, channel_active_o[0]);
      status_clear_i[0] = '1; tick(1); status_clear_i[0] = '0; tick(1);
      check("clear", 0, raw_irq_status_o[0]);
      $display("test chain byte order %0d finished", m);
    end
    // one-entry cyclic list on channel 1: endless, then paused and resumed
    mem_wr(32'h300, 32'h104); mem_wr(32'h304, 32'h210); mem_wr(32'h308, 4);
    mem_wr(32'h30c, 32'h301); host_we_i = 1'b0;
    seed(1, 0, 0, 0, 32'h300);
    wait_flag(1, ST_DONE, 400, n);
    status_clear_i[1] = '1; tick(1); status_clear_i[1] = '0;
    wait_flag(1, ST_DONE, 400, n);
    check("cyc_again", 1, raw_irq_status_o[1][ST_DONE]);
    channel_run_enable_i[1] = 1'b0; tick(60);
    status_clear_i[1] = '1; tick(1); status_clear_i[1] = '0; tick(60);
    check("paused", 0, raw_irq_status_o[1]);
    check("held", 1, channel_active_o[1]);
    mem_rd("cyc_dst", 32'h210, 32'h5566_7788);
    channel_run_enable_i[1] = 1'b1;
    wait_flag(1, ST_DONE, 400, n);
    check("resume", 1, raw_irq_status_o[1][ST_DONE]);
    channel_run_enable_i[1] = 1'b0; tick(60);
    status_clear_i[1] = '1; tick(1); status_clear_i[1] = '0; tick(1);
    $display("test cyclic list finished");
    // slave held off: read beat of channel 2 goes unanswered
    stall_i = 1'b1;
    seed(2, 32'h100, 32'h200, 4, 32'h3);
    wait_flag(2, ST_TO_RD, 1100, n);
    check("to_rd", 1, raw_irq_status_o[2][ST_TO_RD]);
    check("to_masked", 4'h2, masked_irq_status_o[2]);
    check("to_span", 1, n >= 1010 && n <= 1030);
    check("to_other", 0, {raw_irq_status_o[3], raw_irq_status_o[1:0]});
    stall_i = 1'b0; tick(20);
    check("sticky", 1, raw_irq_status_o[2][ST_TO_RD]);
    check("to_wr", 0, raw_irq_status_o[2][ST_TO_WR]);
    $display("test bus time-out finished");
    conclude();
  end
endmodule
